// >>> design/dpsf_fence.sv
// Access security gate for decoder and video-out ports, electronic fence for the decoder port only
//
// Overview of operation
// - Trigger bits 8..0 select decoder trigger sources
// - Bit 23 picks sub-requester 7 trigger level
// - Bits 22..16 are trigger levels for 6..0
// - Decoder ids 0..8 map to fixed requesters
// - Protect bits 24..16 select write-control replacement
// - Protect bits 8..0 select read-control replacement
// - Fire copies selected read values into controls
// - Fire copies selected write values into controls
// - Unused protect and trigger bits do nothing
// - Video-out read register: secure odd, non-secure even
// - Video-out read refused unless region enabled
// - Video-out write register: secure odd, non-secure even
// - Video-out non-secure write needs its enable
// - All enables and selections reset to zero
// - Video-out ids 13, 14 unused but writable
// - Decoder read control pairs, local memory 17:16
// - Selected read at chosen level fires fence
`include "dpsf_regs.svh"

module dpsf_fence #(
  parameter int unsigned DEC_N = dpsf_pkg::DEC_IDS,
  parameter int unsigned VO_N = dpsf_pkg::VO_IDS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_index,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Decoder requests
  input wire dpsf_pkg::dpsf_req_t dec_req,
  output logic dec_allow,
  output logic dec_block,
  // Video-out requests
  input wire dpsf_pkg::dpsf_req_t vo_req,
  output logic vo_allow,
  output logic vo_block,
  // Fence status
  output logic fence_fired
);

  dpsf_pkg::dpsf_state_t st_r;
  dpsf_pkg::dpsf_state_t st_nxt;
  logic dec_rd_ok;
  logic dec_wr_ok;
  logic vo_rd_ok;
  logic vo_wr_ok;
  logic fire;
  logic [2*DEC_N-1:0] rd_mask;
  logic [2*DEC_N-1:0] wr_mask;

  // Decoder ports: ids 0 instruction memory, 1 bitstream, 2 sample offset,
  // 3 and 4 prediction units, 5 and 6 deblocking, 7 motion prediction,
  // 8 local memory
  dpsf_region_gate #(.N(DEC_N), .IDW(dpsf_pkg::ID_W)) u_dec_rd_gate (
    .enables(st_r.dec_rd_sec),
    .valid(dec_req.valid & ~dec_req.write),
    .secure(dec_req.secure),
    .id(dec_req.id),
    .allow(dec_rd_ok)
  );

  dpsf_region_gate #(.N(DEC_N), .IDW(dpsf_pkg::ID_W)) u_dec_wr_gate (
    .enables(st_r.dec_wr_sec),
    .valid(dec_req.valid & dec_req.write),
    .secure(dec_req.secure),
    .id(dec_req.id),
    .allow(dec_wr_ok)
  );

  // Ids 13 and 14 carry no traffic, yet are gated like the rest
  dpsf_region_gate #(.N(VO_N), .IDW(dpsf_pkg::ID_W)) u_vo_rd_gate (
    .enables(st_r.vo_rd_sec),
    .valid(vo_req.valid & ~vo_req.write),
    .secure(vo_req.secure),
    .id(vo_req.id),
    .allow(vo_rd_ok)
  );

  dpsf_region_gate #(.N(VO_N), .IDW(dpsf_pkg::ID_W)) u_vo_wr_gate (
    .enables(st_r.vo_wr_sec),
    .valid(vo_req.valid & vo_req.write),
    .secure(vo_req.secure),
    .id(vo_req.id),
    .allow(vo_wr_ok)
  );

  dpsf_fence_detect #(.N(DEC_N), .IDW(dpsf_pkg::ID_W)) u_detect (
    .trig_sel(st_r.trig_sel),
    .trig_type(st_r.trig_type),
    .accepted(dec_rd_ok),
    .write(dec_req.write),
    .secure(dec_req.secure),
    .id(dec_req.id),
    .fire(fire)
  );

  assign dec_allow = dec_rd_ok | dec_wr_ok;
  assign dec_block = dec_req.valid & ~dec_allow;
  assign vo_allow = vo_rd_ok | vo_wr_ok;
  assign vo_block = vo_req.valid & ~vo_allow;
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign fence_fired = st_r.fence_fire;

  // Each protect bit covers the secure and non-secure enable of its id
  always_comb begin
    rd_mask = '0;
    wr_mask = '0;
    for (int i = 0; i < DEC_N; i++) begin
      rd_mask[2*i+:2] = {2{st_r.prot_rd[i]}};
      wr_mask[2*i+:2] = {2{st_r.prot_wr[i]}};
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = reg_rd_en;
    st_nxt.fence_fire = fire;
    if (reg_wr_en) begin
      case (reg_index)
        `DPSF_IDX_DEC_RD_SEC: begin
          st_nxt.dec_rd_sec = reg_wdata[`DPSF_SEC_MSB:0];
        end
        `DPSF_IDX_DEC_WR_SEC: begin
          st_nxt.dec_wr_sec = reg_wdata[`DPSF_SEC_MSB:0];
        end
        `DPSF_IDX_TRIG_SEL: begin
          st_nxt.trig_sel = reg_wdata[`DPSF_SEL_MSB:`DPSF_SEL_LSB];
          // Bit 23 is sub-requester 7, bits 22..16 are 6..0
          st_nxt.trig_type = reg_wdata[`DPSF_HI_MSB:`DPSF_HI_LSB];
        end
        `DPSF_IDX_PROT_SEL: begin
          st_nxt.prot_rd = reg_wdata[`DPSF_SEL_MSB:`DPSF_SEL_LSB];
          st_nxt.prot_wr = reg_wdata[`DPSF_HI_MSB:`DPSF_HI_LSB];
        end
        `DPSF_IDX_EF_READ: begin
          st_nxt.ef_rd = reg_wdata[`DPSF_SEC_MSB:0];
        end
        `DPSF_IDX_EF_WRITE: begin
          st_nxt.ef_wr = reg_wdata[`DPSF_SEC_MSB:0];
        end
        `DPSF_IDX_VO_RD_SEC: begin
          st_nxt.vo_rd_sec = reg_wdata;
        end
        `DPSF_IDX_VO_WR_SEC: begin
          st_nxt.vo_wr_sec = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    // The fence beats a software write landing in the same cycle, so a
    // racing write cannot reopen a region the fence is closing
    if (fire) begin
      st_nxt.dec_rd_sec = (st_nxt.dec_rd_sec & ~rd_mask) |
                          (st_r.ef_rd & rd_mask);
      st_nxt.dec_wr_sec = (st_nxt.dec_wr_sec & ~wr_mask) |
                          (st_r.ef_wr & wr_mask);
    end
    if (reg_rd_en) begin
      case (reg_index)
        `DPSF_IDX_DEC_RD_SEC: st_nxt.rdata = {14'h0000, st_r.dec_rd_sec};
        `DPSF_IDX_DEC_WR_SEC: st_nxt.rdata = {14'h0000, st_r.dec_wr_sec};
        `DPSF_IDX_TRIG_SEL: begin
          st_nxt.rdata = {7'h00, st_r.trig_type, 7'h00, st_r.trig_sel};
        end
        `DPSF_IDX_PROT_SEL: begin
          st_nxt.rdata = {7'h00, st_r.prot_wr, 7'h00, st_r.prot_rd};
        end
        `DPSF_IDX_EF_READ: st_nxt.rdata = {14'h0000, st_r.ef_rd};
        `DPSF_IDX_EF_WRITE: st_nxt.rdata = {14'h0000, st_r.ef_wr};
        `DPSF_IDX_VO_RD_SEC: st_nxt.rdata = st_r.vo_rd_sec;
        `DPSF_IDX_VO_WR_SEC: st_nxt.rdata = st_r.vo_wr_sec;
        default: st_nxt.rdata = `DPSF_RST_VAL;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_trig_source_sel:
    assert property (fire |-> dec_req.id <= 4'h8 &&
                     st_r.trig_sel[dec_req.id])
    else $error("fence fired from an unselected sub-requester");

  a_trig_type_seven:
    assert property (fire && dec_req.id == 4'h7 |->
                     dec_req.secure == st_r.trig_type[7])
    else $error("sub-requester 7 fired at the wrong level");

  a_trig_type_write:
    assert property (reg_wr_en && reg_index == `DPSF_IDX_TRIG_SEL |=>
                     st_r.trig_type == $past(reg_wdata[24:16]) &&
                     st_r.trig_sel == $past(reg_wdata[8:0]))
    else $error("trigger register write not stored");

  a_wr_copy_sel:
    assert property (fire |=> ((st_r.dec_wr_sec ^ $past(st_r.ef_wr)) &
                     $past(wr_mask)) == 18'h0_0000)
    else $error("selected write controls not replaced");

  a_rd_copy_sel:
    assert property (fire |=> ((st_r.dec_rd_sec ^ $past(st_r.ef_rd)) &
                     $past(rd_mask)) == 18'h0_0000)
    else $error("selected read controls not replaced");

  a_rd_copy_keep:
    assert property (fire && !reg_wr_en |=> ((st_r.dec_rd_sec ^
                     $past(st_r.dec_rd_sec)) & ~$past(rd_mask)) == 18'h0_0000)
    else $error("unselected read controls changed by the fence");

  a_wr_copy_keep:
    assert property (fire && !reg_wr_en |=> ((st_r.dec_wr_sec ^
                     $past(st_r.dec_wr_sec)) & ~$past(wr_mask)) == 18'h0_0000)
    else $error("unselected write controls changed by the fence");

  a_prot_unused_zero:
    assert property (reg_rd_en && reg_index == `DPSF_IDX_PROT_SEL |=>
                     reg_rvalid && reg_rdata[31:25] == 7'h00 &&
                     reg_rdata[15:9] == 7'h00)
    else $error("unused protect bits read non-zero");

  a_vo_read_gate:
    assert property (vo_req.valid && !vo_req.write |->
                     vo_allow == st_r.vo_rd_sec[{vo_req.id, vo_req.secure}])
    else $error("video-out read verdict disagrees with enable");

  a_vo_write_ns:
    assert property (vo_req.valid && vo_req.write && !vo_req.secure |->
                     vo_allow == st_r.vo_wr_sec[{vo_req.id, 1'b0}])
    else $error("video-out non-secure write verdict wrong");

  // Looked at on the first edge after release, when the flops are known
  a_reset_closed:
    assert property (disable iff (1'b0) $fell(sys_rst) |->
                     st_r.vo_rd_sec == 32'h0000_0000 && !dec_allow &&
                     st_r.trig_sel == 9'h000 && st_r.prot_rd == 9'h000)
    else $error("state not cleared by reset");

  a_dec_lmem_read:
    assert property (dec_req.valid && !dec_req.write && dec_req.id == 4'h8
                     |-> dec_allow == (dec_req.secure ? st_r.dec_rd_sec[17]
                     : st_r.dec_rd_sec[16]))
    else $error("local memory read verdict wrong");

  a_fire_pulse:
    assert property (dec_allow && !dec_req.write && dec_req.id <= 4'h8 &&
                     st_r.trig_sel[dec_req.id] &&
                     dec_req.secure == st_r.trig_type[dec_req.id]
                     |=> fence_fired)
    else $error("selected read at trigger level did not fire");

  a_block_excl:
    assert property (dec_req.valid |-> dec_allow != dec_block)
    else $error("decoder request both allowed and blocked");

  // Fence behaviour
  a_copy_visible:
    assert property (fire && !reg_wr_en ##1 dec_req.valid && !dec_req.write
                     && dec_req.id <= 4'h8 && st_r.prot_rd[dec_req.id]
                     |-> dec_allow ==
                     st_r.ef_rd[{dec_req.id, dec_req.secure}])
    else $error("request after the fence not judged by fence values");

  a_dec_id_range:
    assert property (dec_req.valid && dec_req.id > 4'h8 |-> dec_block)
    else $error("decoder request from an unknown id let through");

  a_fire_is_read:
    assert property (fire |-> dec_allow && !dec_req.write)
    else $error("fence fired without an accepted read");

  a_dec_write_gate:
    assert property (dec_req.valid && dec_req.write && dec_req.id <= 4'h8 |->
                     dec_allow ==
                     st_r.dec_wr_sec[{dec_req.id, dec_req.secure}])
    else $error("decoder write verdict disagrees with enable");

  // Register stores: each write's fields land at the next edge
  a_prot_write:
    assert property (reg_wr_en && reg_index == `DPSF_IDX_PROT_SEL |=>
                     st_r.prot_wr == $past(reg_wdata[24:16]) &&
                     st_r.prot_rd == $past(reg_wdata[8:0]))
    else $error("protect register write not stored");

  a_ef_rd_write:
    assert property (reg_wr_en && reg_index == `DPSF_IDX_EF_READ |=>
                     st_r.ef_rd == $past(reg_wdata[17:0]))
    else $error("fence read values not stored");

  a_ef_wr_write:
    assert property (reg_wr_en && reg_index == `DPSF_IDX_EF_WRITE |=>
                     st_r.ef_wr == $past(reg_wdata[17:0]))
    else $error("fence write values not stored");

  a_vo_rd_reg:
    assert property (reg_wr_en && reg_index == `DPSF_IDX_VO_RD_SEC |=>
                     st_r.vo_rd_sec == $past(reg_wdata))
    else $error("video-out read enables not stored");

  a_vo_wr_reg:
    assert property (reg_wr_en && reg_index == `DPSF_IDX_VO_WR_SEC |=>
                     st_r.vo_wr_sec == $past(reg_wdata))
    else $error("video-out write enables not stored");

  // Video-out gates
  a_vo_write_sec:
    assert property (vo_req.valid && vo_req.write && vo_req.secure |->
                     vo_allow == st_r.vo_wr_sec[{vo_req.id, 1'b1}])
    else $error("video-out secure write verdict wrong");

  a_vo_spare_ids:
    assert property (vo_req.valid && !vo_req.write &&
                     (vo_req.id == 4'hd || vo_req.id == 4'he) |->
                     vo_block == !st_r.vo_rd_sec[{vo_req.id, vo_req.secure}])
    else $error("spare video-out id not gated by its enable");

  a_vo_block_excl:
    assert property (vo_req.valid |-> vo_allow != vo_block)
    else $error("video-out request both allowed and blocked");

  c_lmem_read: cover property (dec_allow && !dec_req.write &&
                               dec_req.id == 4'h8);
  c_fence_fire: cover property (fire ##1 fence_fired);
  c_vo_blocked: cover property (vo_block);
  c_dec_allowed: cover property (dec_allow && dec_req.write);
  c_reg_read: cover property (reg_rd_en ##1 reg_rvalid);

endmodule : dpsf_fence

// >>> design/dpsf_regs.svh
// Register indices, field positions and reset values of the security fence
`ifndef DPSF_REGS_SVH
`define DPSF_REGS_SVH

// Register indices on the register port; byte address is four times these
`define DPSF_IDX_DEC_RD_SEC 8'h1e
`define DPSF_IDX_DEC_WR_SEC 8'h1f
`define DPSF_IDX_TRIG_SEL 8'h21
`define DPSF_IDX_PROT_SEL 8'h22
`define DPSF_IDX_EF_READ 8'h23
`define DPSF_IDX_EF_WRITE 8'h24
`define DPSF_IDX_VO_RD_SEC 8'h32
`define DPSF_IDX_VO_WR_SEC 8'h33

// Field positions
`define DPSF_SEL_LSB 0
`define DPSF_SEL_MSB 8
`define DPSF_HI_LSB 16
`define DPSF_HI_MSB 24
`define DPSF_SEC_MSB 17
`define DPSF_LMEM_ID 8

// Reset value of every register
`define DPSF_RST_VAL 32'h0000_0000

`endif

// >>> design/dpsf_pkg.sv
// Types shared by the security fence modules
package dpsf_pkg;

  localparam int unsigned DEC_IDS = 9;
  localparam int unsigned VO_IDS = 16;
  localparam int unsigned ID_W = 4;

  // One memory request as seen by the fence
  typedef struct packed {
    logic valid;
    logic write;
    logic secure;
    logic [ID_W-1:0] id;
  } dpsf_req_t;

  // Whole state of the top module
  typedef struct packed {
    logic [2*DEC_IDS-1:0] dec_rd_sec;
    logic [2*DEC_IDS-1:0] dec_wr_sec;
    logic [DEC_IDS-1:0] trig_sel;
    logic [DEC_IDS-1:0] trig_type;
    logic [DEC_IDS-1:0] prot_rd;
    logic [DEC_IDS-1:0] prot_wr;
    logic [2*DEC_IDS-1:0] ef_rd;
    logic [2*DEC_IDS-1:0] ef_wr;
    logic [2*VO_IDS-1:0] vo_rd_sec;
    logic [2*VO_IDS-1:0] vo_wr_sec;
    logic [31:0] rdata;
    logic rvalid;
    logic fence_fire;
  } dpsf_state_t;

endpackage : dpsf_pkg

// >>> design/dpsf_region_gate.sv
// Per-requester region gate: picks the enable bit for an id and region
module dpsf_region_gate #(
  parameter int unsigned N = 9,
  parameter int unsigned IDW = 4
) (
  // Enable pairs, secure bit above non-secure bit
  input wire logic [2*N-1:0] enables,
  // Request
  input wire logic valid,
  input wire logic secure,
  input wire logic [IDW-1:0] id,
  // Verdict
  output logic allow
);

  // Ids of N and above have no enable pair and are always refused
  always_comb begin
    allow = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (id == IDW'(i)) begin
        allow = valid & (secure ? enables[2*i+1] : enables[2*i]);
      end
    end
  end

endmodule : dpsf_region_gate

// >>> design/dpsf_fence_detect.sv
// Fence trigger detection on accepted decoder reads
module dpsf_fence_detect #(
  parameter int unsigned N = 9,
  parameter int unsigned IDW = 4
) (
  // Trigger configuration
  input wire logic [N-1:0] trig_sel,
  input wire logic [N-1:0] trig_type,
  // Accepted request
  input wire logic accepted,
  input wire logic write,
  input wire logic secure,
  input wire logic [IDW-1:0] id,
  // Trigger
  output logic fire
);

  always_comb begin
    fire = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (id == IDW'(i)) begin
        fire = accepted & ~write & trig_sel[i] & (trig_type[i] == secure);
      end
    end
  end

endmodule : dpsf_fence_detect

// >>> verification/dpsf_req_model.sv
// Behavioural memory requester feeding one request port of the fence
module dpsf_req_model (
  // Clock
  input wire logic clock,
  // Request toward the fence
  output dpsf_pkg::dpsf_req_t req
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req = '0;

  // Launch one request just after an edge; it stands until the next drive or idle
  task automatic drive(input logic w, input logic s, input logic [3:0] id);
    @(posedge clock);
    #1;
    req = {1'b1, w, s, id};
  endtask : drive

  // Released fields show the inverse so stale values never pass for valid
  task automatic idle();
    @(posedge clock);
    #1;
    req = {1'b0, ~req.write, ~req.secure, ~req.id};
  endtask : idle
endmodule : dpsf_req_model

// >>> verification/dpsf_fence_tb_top.sv
// Self-checking bench for the security fence
module dpsf_fence_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock, sys_rst, reg_wr_en, reg_rd_en, reg_rvalid, fence_fired;
  logic dec_allow, dec_block, vo_allow, vo_block;
  logic [7:0] reg_index;
  logic [31:0] reg_wdata, reg_rdata;
  dpsf_pkg::dpsf_req_t dec_req, vo_req;
  int errors = 0;
  int checks = 0;

  dpsf_fence dpsf_fence_inst (.clock(clock), .sys_rst(sys_rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .dec_req(dec_req), .dec_allow(dec_allow), .dec_block(dec_block),
    .vo_req(vo_req), .vo_allow(vo_allow), .vo_block(vo_block),
    .fence_fired(fence_fired));
  dpsf_req_model dec_model (.clock(clock), .req(dec_req));
  dpsf_req_model vo_model (.clock(clock), .req(vo_req));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk32(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic reg_wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge clock);
    #1;
    reg_wr_en = 1'b1;
    reg_index = idx;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr_en = 1'b0;
  endtask : reg_wr

  // Read answer is due at the same edge that takes the strobe
  task automatic reg_rd(input logic [7:0] idx, input logic [31:0] exp);
    @(posedge clock);
    #1;
    reg_rd_en = 1'b1;
    reg_index = idx;
    @(posedge clock);
    #1;
    reg_rd_en = 1'b0;
    chk1(reg_rvalid, 1'b1, "rvalid");
    chk32(reg_rdata, exp, "rdata");
  endtask : reg_rd

  task automatic vo_try(input logic w, s, input logic [3:0] id, input logic e);
    vo_model.drive(w, s, id);
    #2;
    chk1(vo_allow, e, "vo allow");
    chk1(vo_block, ~e, "vo block");
  endtask : vo_try

  // f is the fence pulse expected from the previous cycle's request
  task automatic dec_try(input logic w, s, input logic [3:0] id,
                         input logic e, f);
    dec_model.drive(w, s, id);
    #2;
    chk1(dec_allow, e, "dec allow");
    chk1(dec_block, ~e, "dec block");
    chk1(fence_fired, f, "fence pulse");
  endtask : dec_try

  task automatic test_reset();
    logic [7:0] idx [6] = '{8'h1e, 8'h1f, 8'h21, 8'h22, 8'h32, 8'h33};
    foreach (idx[i]) reg_rd(idx[i], 32'h0000_0000);
    vo_try(1'b0, 1'b1, 4'h0, 1'b0);
    dec_try(1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
    vo_model.idle();
    dec_model.idle();
    $display("test reset done");
  endtask : test_reset

  // Every id and both regions; ids 13 and 14 are gated like the rest
  task automatic test_vo();
    logic [31:0] rp = 32'hA5C3_0F96;
    logic [31:0] wp = 32'h3C5A_F069;
    reg_wr(8'h32, rp);
    reg_wr(8'h33, wp);
    reg_rd(8'h32, rp);
    reg_rd(8'h33, wp);
    for (int n = 0; n < 32; n++) begin
      vo_try(1'b0, n[0], n[4:1], rp[n]);
      vo_try(1'b1, n[0], n[4:1], wp[n]);
    end
    vo_model.idle();
    $display("test video out done");
  endtask : test_vo

  task automatic test_fields();
    reg_wr(8'h21, 32'hFFFF_FFFF);
    reg_rd(8'h21, 32'h01FF_01FF);
    reg_wr(8'h22, 32'hFFFF_FFFF);
    reg_rd(8'h22, 32'h01FF_01FF);
    reg_wr(8'h23, 32'hFFFF_FFFF);
    reg_rd(8'h23, 32'h0003_FFFF);
    reg_wr(8'h40, 32'hFFFF_FFFF);
    reg_rd(8'h40, 32'h0000_0000);
    $display("test fields done");
  endtask : test_fields

  // Id 3 secure read fires; id 5 controls are replaced for the next cycle
  task automatic test_fence();
    reg_wr(8'h1e, 32'h0000_00C0);
    reg_wr(8'h1f, 32'h0000_0000);
    reg_wr(8'h21, 32'h0008_0008);
    reg_wr(8'h22, 32'h0020_0020);
    reg_wr(8'h23, 32'h0000_0C00);
    reg_wr(8'h24, 32'h0000_0400);
    dec_try(1'b0, 1'b0, 4'h5, 1'b0, 1'b0);
    dec_try(1'b0, 1'b0, 4'h3, 1'b1, 1'b0);
    dec_try(1'b0, 1'b1, 4'h3, 1'b1, 1'b0);
    dec_try(1'b0, 1'b0, 4'h5, 1'b1, 1'b1);
    dec_try(1'b1, 1'b0, 4'h5, 1'b1, 1'b0);
    dec_try(1'b1, 1'b1, 4'h5, 1'b0, 1'b0);
    dec_try(1'b0, 1'b1, 4'h9, 1'b0, 1'b0);
    dec_model.idle();
    reg_rd(8'h1e, 32'h0000_0CC0);
    reg_rd(8'h1f, 32'h0000_0400);
    $display("test fence done");
  endtask : test_fence

  // Id 7 fires on a non-secure read; local memory writes open afterwards
  task automatic test_fence_lmem();
    reg_wr(8'h1e, 32'h0001_C000);
    reg_wr(8'h1f, 32'h0000_0000);
    reg_wr(8'h21, 32'h0000_0080);
    reg_wr(8'h22, 32'h0100_0080);
    reg_wr(8'h23, 32'h0000_0000);
    reg_wr(8'h24, 32'h0003_0000);
    dec_try(1'b0, 1'b0, 4'h8, 1'b1, 1'b0);
    dec_try(1'b0, 1'b1, 4'h8, 1'b0, 1'b0);
    dec_try(1'b0, 1'b1, 4'h7, 1'b1, 1'b0);
    dec_try(1'b0, 1'b0, 4'h7, 1'b1, 1'b0);
    dec_try(1'b0, 1'b0, 4'h7, 1'b0, 1'b1);
    dec_try(1'b1, 1'b1, 4'h8, 1'b1, 1'b0);
    dec_model.idle();
    reg_rd(8'h1e, 32'h0001_0000);
    reg_rd(8'h1f, 32'h0003_0000);
    $display("test fence local memory done");
  endtask : test_fence_lmem

  // A reset in mid-run must close what the earlier tests opened
  task automatic test_mid_reset();
    @(posedge clock);
    #1;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    test_reset();
    dec_try(1'b0, 1'b0, 4'h8, 1'b0, 1'b0);
    dec_model.idle();
    $display("test mid-run reset done");
  endtask : test_mid_reset

  initial begin
    sys_rst = 1'b1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_index = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (8) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    test_reset();
    test_vo();
    test_fields();
    test_fence();
    test_fence_lmem();
    test_mid_reset();
    complete_run();
  end

  // Whole sequence needs well under 1000 cycles
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule : dpsf_fence_tb_top
